// ---- hdl/rzb_output_stage.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rzb_regs.svh"
module rzb_output_stage #(
    parameter int LINE_MAX = 2048
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // resized pixels in
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_sof,
    input wire logic in_eol,
    input wire logic [7:0] in_y,
    input wire logic [7:0] in_cb,
    input wire logic [7:0] in_cr,
    // packed pixels out
    input wire logic out_ready,
    output logic out_valid,
    output logic [31:0] out_data,
    output logic out_last
);

    localparam int COLW = $clog2(LINE_MAX);

    // the column memory needs at least two entries to address
    if (LINE_MAX < 2 || LINE_MAX > 65536) begin : g_chk
        $error("rzb_output_stage: LINE_MAX out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // state of the whole block
    typedef struct packed {
        logic [5:0] lpf_c; // chroma filter strength
        logic [5:0] lpf_y; // luma filter strength
        logic dwn_en; // averaging mode on
        logic [2:0] av_v; // vertical block code
        logic [2:0] av_h; // horizontal block code
        logic rgb_en; // rgb output selected
        logic msk_last; // drop last two pixels
        logic msk_first; // drop first two pixels
        logic pack16; // 5:6:5 packing
        logic [7:0] alpha; // alpha byte for 32-bit packing
        logic [31:0] prdata; // latched read data
        logic pready; // bus answer
        logic pslverr; // unmapped address
        logic in_ready; // input accepted next edge
        rzb_pkg::rzb_ycc_t prev; // previous raw input sample
        logic mid_line; // a sample of this line was seen
        logic [7:0] hcnt; // samples in current block
        rzb_pkg::rzb_acc_t hacc; // horizontal running sum
        logic [COLW-1:0] col; // output column in the line
        logic [7:0] vline; // line within vertical block
        rzb_pkg::rzb_ycc_t held; // sample waiting for its successor
        logic held_v; // held sample present
        logic flush; // held sample ends its line
        logic [1:0] opix; // samples left this line, saturating
        logic [15:0] lines; // lines taken since reset
        logic out_valid;
        logic [31:0] out_data;
        logic out_last;
    } rzb_state_t;

    rzb_state_t s_reg; // registered state
    rzb_state_t s_next; // next state

    // column memory for vertical sums
    rzb_pkg::rzb_acc_t line_mem [LINE_MAX];
    logic mem_we; // write vertical partial sum
    rzb_pkg::rzb_acc_t mem_wd; // value written
    rzb_pkg::rzb_acc_t mem_rd; // sum of earlier lines at this column

    // datapath intermediates
    logic fire; // input sample taken this edge
    logic [7:0] vl; // line index, forced to zero at frame start
    rzb_pkg::rzb_ycc_t cur; // raw input sample
    rzb_pkg::rzb_ycc_t nbr; // neighbour for the filter
    rzb_pkg::rzb_ycc_t filt; // filtered sample
    rzb_pkg::rzb_acc_t hsum; // block sum including this sample
    rzb_pkg::rzb_ycc_t hval; // horizontal average
    rzb_pkg::rzb_acc_t vsum; // vertical sum including this line
    rzb_pkg::rzb_ycc_t samp; // finished output sample
    logic samp_v; // a sample finished
    logic go; // held sample leaves
    logic drop; // leaving sample is masked
    logic head; // leaving sample is among the first two
    logic [31:0] rdv; // read value before latching
    logic rd_hit; // read address decodes

    rzb_pix_if pif();

    // converter works on the held sample
    assign pif.pix = s_reg.held;
    assign pif.alpha = s_reg.alpha;
    assign pif.rgb_en = s_reg.rgb_en;
    assign pif.pack16 = s_reg.pack16;

    rzb_pack u_pack (
        .pif(pif.conv)
    );

    assign mem_rd = line_mem[s_reg.col];

    ////////////////////////////////////////////////////////////////////////
    // read decode; unused and reserved bits read as zero
    always_comb begin
        rdv = 32'h0000_0000; // R3
        rd_hit = 1'b1;
        if (paddr == `RZB_OFS_HLPF) begin
            rdv[`RZB_LPF_C_MSB:`RZB_LPF_C_LSB] = s_reg.lpf_c;
            rdv[`RZB_LPF_Y_MSB:`RZB_LPF_Y_LSB] = s_reg.lpf_y;
        end else if (paddr == `RZB_OFS_DWN_EN) begin
            rdv[`RZB_EN_BIT] = s_reg.dwn_en;
        end else if (paddr == `RZB_OFS_DWN_AV) begin
            rdv[`RZB_AV_V_MSB:`RZB_AV_V_LSB] = s_reg.av_v;
            rdv[`RZB_AV_H_MSB:`RZB_AV_H_LSB] = s_reg.av_h;
        end else if (paddr == `RZB_OFS_RGB_EN) begin
            rdv[`RZB_EN_BIT] = s_reg.rgb_en;
        end else if (paddr == `RZB_OFS_RGB_TYP) begin
            rdv[`RZB_MSK_LAST_BIT] = s_reg.msk_last;
            rdv[`RZB_MSK_FIRST_BIT] = s_reg.msk_first;
            rdv[`RZB_PACK16_BIT] = s_reg.pack16;
        end else if (paddr == `RZB_OFS_ALPHA) begin
            rdv[`RZB_ALPHA_MSB:`RZB_ALPHA_LSB] = s_reg.alpha;
        end else if (paddr == `RZB_OFS_STATUS) begin
            // line count and pipeline occupancy
            rdv = {s_reg.lines, 13'h0000, s_reg.flush, s_reg.held_v, s_reg.out_valid};
        end else begin
            rd_hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: bus, filter, averaging, masking, output
    always_comb begin
        s_next = s_reg;
        mem_we = 1'b0;
        mem_wd = '0;
        samp = '0;
        samp_v = 1'b0;
        go = 1'b0;
        drop = 1'b0;

        // bus: zero wait states; read data and error latched in setup
        s_next.pready = 1'b1;
        if (psel && !penable) begin
            s_next.prdata = rdv;
            s_next.pslverr = !rd_hit;
        end
        // writes land at the access edge; only defined fields are kept
        if (psel && penable && pwrite) begin
            if (paddr == `RZB_OFS_HLPF) begin
                s_next.lpf_c = pwdata[`RZB_LPF_C_MSB:`RZB_LPF_C_LSB]; // R1
                s_next.lpf_y = pwdata[`RZB_LPF_Y_MSB:`RZB_LPF_Y_LSB]; // R2
            end else if (paddr == `RZB_OFS_DWN_EN) begin
                s_next.dwn_en = pwdata[`RZB_EN_BIT]; // R4
            end else if (paddr == `RZB_OFS_DWN_AV) begin
                s_next.av_v = pwdata[`RZB_AV_V_MSB:`RZB_AV_V_LSB]; // R5
                s_next.av_h = pwdata[`RZB_AV_H_MSB:`RZB_AV_H_LSB]; // R6
            end else if (paddr == `RZB_OFS_RGB_EN) begin
                s_next.rgb_en = pwdata[`RZB_EN_BIT]; // R8
            end else if (paddr == `RZB_OFS_RGB_TYP) begin
                s_next.msk_last = pwdata[`RZB_MSK_LAST_BIT]; // R9
                s_next.msk_first = pwdata[`RZB_MSK_FIRST_BIT]; // R10
                s_next.pack16 = pwdata[`RZB_PACK16_BIT]; // R11 R12
            end else if (paddr == `RZB_OFS_ALPHA) begin
                s_next.alpha = pwdata[`RZB_ALPHA_MSB:`RZB_ALPHA_LSB]; // R13
            end
        end

        // horizontal lowpass; a line's first sample filters against itself
        fire = in_valid && s_reg.in_ready;
        cur = {in_y, in_cb, in_cr};
        nbr = s_reg.mid_line ? s_reg.prev : cur;
        filt.y = rzb_pkg::rzb_lpf(cur.y, nbr.y, s_reg.lpf_y); // R2
        filt.cb = rzb_pkg::rzb_lpf(cur.cb, nbr.cb, s_reg.lpf_c); // R1
        filt.cr = rzb_pkg::rzb_lpf(cur.cr, nbr.cr, s_reg.lpf_c); // R1

        // block averaging sums; frame start restarts the vertical block
        vl = (in_sof && !s_reg.mid_line) ? 8'h00 : s_reg.vline;
        hsum = rzb_pkg::rzb_acc_add(s_reg.hacc, filt);
        hval = rzb_pkg::rzb_acc_avg(hsum, s_reg.av_h); // R6
        vsum = rzb_pkg::rzb_acc_add((vl == 8'h00) ? '0 : mem_rd, hval);

        // a leaving sample is among the first two of its line
        head = s_reg.opix < 2'h2;

        if (fire) begin
            s_next.prev = cur;
            s_next.mid_line = !in_eol;
            if (!s_reg.dwn_en) begin
                // averaging off: every filtered sample goes on
                samp = filt; // R4
                samp_v = 1'b1;
            end else if (s_reg.hcnt == rzb_pkg::rzb_span(s_reg.av_h) || in_eol) begin
                // horizontal block complete (a short tail still divides by full size)
                s_next.hacc = '0; // R15
                s_next.hcnt = 8'h00;
                if (s_reg.col != COLW'(LINE_MAX - 1)) begin
                    s_next.col = s_reg.col + 1'b1;
                end
                if (vl == rzb_pkg::rzb_span(s_reg.av_v)) begin
                    samp = rzb_pkg::rzb_acc_avg(vsum, s_reg.av_v); // R5 R15
                    samp_v = 1'b1;
                end else begin
                    mem_we = 1'b1; // R15
                    mem_wd = vsum;
                end
            end else begin
                s_next.hacc = hsum; // R15
                s_next.hcnt = s_reg.hcnt + 8'h01;
            end

            // line end: rewind the column and step the vertical block
            if (in_eol) begin
                s_next.col = '0;
                s_next.hacc = '0;
                s_next.hcnt = 8'h00;
                s_next.lines = s_reg.lines + 16'h0001;
                if (!s_reg.dwn_en || vl == rzb_pkg::rzb_span(s_reg.av_v)) begin
                    s_next.vline = 8'h00;
                end else begin
                    s_next.vline = vl + 8'h01;
                end
            end

            // a new sample pushes the held one out; if the new one ends
            // the line, the held one is second to last
            if (samp_v) begin
                if (s_reg.held_v) begin
                    go = 1'b1;
                    drop = s_reg.rgb_en && ((s_reg.msk_first && head) // R10
                        || (s_reg.msk_last && in_eol)); // R9
                end
                s_next.held = samp;
                s_next.held_v = 1'b1;
                s_next.flush = in_eol;
            end
        end else if (s_reg.flush && (!s_reg.out_valid || out_ready)) begin
            // the held sample ends its line and leaves alone
            go = 1'b1;
            drop = s_reg.rgb_en && (s_reg.msk_last || (s_reg.msk_first && head)); // R9 R10
            s_next.held_v = 1'b0;
            s_next.flush = 1'b0;
        end

        // count samples leaving within the line, restart after its last
        if (go) begin
            if (s_reg.flush && !fire) begin
                s_next.opix = 2'h0;
            end else if (s_reg.opix != 2'h3) begin
                s_next.opix = s_reg.opix + 2'h1;
            end
        end

        // output register: drained by the writer, loaded by a leaving sample
        if (s_reg.out_valid && out_ready) begin
            s_next.out_valid = 1'b0;
        end
        if (go && !drop) begin
            s_next.out_valid = 1'b1;
            s_next.out_data = pif.word; // R8 R11 R12
            s_next.out_last = s_reg.flush && !fire;
        end

        // take input only when a leaving sample is sure to find room;
        // this costs every other cycle but keeps ready a plain flop
        s_next.in_ready = !s_next.out_valid && !s_next.flush;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; all fields clear at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // column memory holds no reset; the first line of a block never reads it
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            line_mem[s_reg.col] <= mem_wd;
        end
    end

    // outputs straight from the state register
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign in_ready = s_reg.in_ready;
    assign out_valid = s_reg.out_valid;
    assign out_data = s_reg.out_data;
    assign out_last = s_reg.out_last;

endmodule
`default_nettype wire

// ---- shared/rzb_regs.svh ----
// Overview of operation
// R1 - chroma lowpass strength bits 11..6, 0 to 32
// R2 - luma lowpass strength bits 5..0, 0 to 32
// R3 - reserved bits written zero, read zero
// R4 - downscale enable bit 0 turns averaging on
// R5 - vertical averaging code bits 5..3: 1/2..1/256
// R6 - horizontal averaging code bits 2..0, same coding
// R7 - software keeps vertical code <=2 when horizontal is 0
// R8 - colour output bit 0: YCbCr or RGB
// R9 - format bit 2 drops last two pixels
// R10 - format bit 1 drops first two pixels
// R11 - format bit 0 low: 32-bit alpha,R,G,B
// R12 - format bit 0 high: 16-bit 5:6:5 RGB
// R13 - alpha byte from alpha constant register
// R14 - software keeps resize ratios in range
// R15 - output sample averages power-of-two input block
`ifndef RZB_REGS_SVH
`define RZB_REGS_SVH

// register byte offsets
`define RZB_OFS_HLPF 12'h000
`define RZB_OFS_DWN_EN 12'h004
`define RZB_OFS_DWN_AV 12'h008
`define RZB_OFS_RGB_EN 12'h00c
`define RZB_OFS_RGB_TYP 12'h010
`define RZB_OFS_ALPHA 12'h014
`define RZB_OFS_STATUS 12'h018

// field positions
`define RZB_LPF_C_MSB 11
`define RZB_LPF_C_LSB 6
`define RZB_LPF_Y_MSB 5
`define RZB_LPF_Y_LSB 0
`define RZB_EN_BIT 0
`define RZB_AV_V_MSB 5
`define RZB_AV_V_LSB 3
`define RZB_AV_H_MSB 2
`define RZB_AV_H_LSB 0
`define RZB_MSK_LAST_BIT 2
`define RZB_MSK_FIRST_BIT 1
`define RZB_PACK16_BIT 0
`define RZB_ALPHA_MSB 7
`define RZB_ALPHA_LSB 0

// reset value of every register
`define RZB_RST_ZERO 32'h0000_0000

// filter strength ceiling and its shift
`define RZB_LPF_MAX 6'h20
`define RZB_LPF_SHIFT 5

// colour conversion coefficients in 1/256 units
`define RZB_CSC_OFS 18'sh00080
`define RZB_CSC_RV 18'sh00167
`define RZB_CSC_GU 18'sh00058
`define RZB_CSC_GV 18'sh000b7
`define RZB_CSC_BU 18'sh001c6
`define RZB_CSC_SHIFT 8

`endif

// ---- shared/rzb_pkg.sv ----
`include "rzb_regs.svh"
package rzb_pkg;

    // one pixel with all three components
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } rzb_ycc_t;

    // running sums for block averaging
    typedef struct packed {
        logic [15:0] y;
        logic [15:0] cb;
        logic [15:0] cr;
    } rzb_acc_t;

    // saturate a signed result to one byte
    function automatic logic [7:0] rzb_clamp(input logic signed [17:0] v);
        if (v < 18'sh00000) begin
            return 8'h00;
        end else if (v > 18'sh000ff) begin
            return 8'hff;
        end
        return v[7:0];
    endfunction

    // block size minus one for an averaging code
    function automatic logic [7:0] rzb_span(input logic [2:0] c);
        return 8'((9'h002 << c) - 9'h001);
    endfunction

    // blend a sample toward its two-tap mean by strength/32
    function automatic logic [7:0] rzb_lpf(input logic [7:0] cur, input logic [7:0] prv,
                                           input logic [5:0] s);
        logic [5:0] sc;
        logic [8:0] avg;
        logic [14:0] acc;
        sc = (s > `RZB_LPF_MAX) ? `RZB_LPF_MAX : s;
        avg = ({1'b0, cur} + {1'b0, prv}) >> 1;
        acc = ({7'h00, cur} * {9'h000, `RZB_LPF_MAX - sc}) + ({7'h00, avg[7:0]} * {9'h000, sc});
        return acc[12:5];
    endfunction

    // add one pixel into a running sum
    function automatic rzb_acc_t rzb_acc_add(input rzb_acc_t a, input rzb_ycc_t p);
        rzb_acc_t r;
        r.y = a.y + {8'h00, p.y};
        r.cb = a.cb + {8'h00, p.cb};
        r.cr = a.cr + {8'h00, p.cr};
        return r;
    endfunction

    // divide a running sum by the block size of a code
    function automatic rzb_ycc_t rzb_acc_avg(input rzb_acc_t a, input logic [2:0] c);
        logic [3:0] sh;
        logic [15:0] y;
        logic [15:0] cb;
        logic [15:0] cr;
        sh = {1'b0, c} + 4'h1;
        y = a.y >> sh;
        cb = a.cb >> sh;
        cr = a.cr >> sh;
        return {y[7:0], cb[7:0], cr[7:0]};
    endfunction

endpackage

// ---- shared/rzb_pix_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// pixel handed to the converter and the packed word it returns
interface rzb_pix_if;
    rzb_pkg::rzb_ycc_t pix;
    logic [7:0] alpha;
    logic rgb_en;
    logic pack16;
    logic [31:0] word;
    modport feed (output pix, output alpha, output rgb_en, output pack16, input word);
    modport conv (input pix, input alpha, input rgb_en, input pack16, output word);
endinterface
`default_nettype wire

// ---- hdl/rzb_pack.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rzb_regs.svh"
module rzb_pack (
    // pixel in, packed word out
    rzb_pix_if.conv pif
);
    logic signed [17:0] ys;
    logic signed [17:0] du;
    logic signed [17:0] dv;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;

    ////////////////////////////////////////////////////////////////////////
    // ycbcr to rgb; chroma is centred on 128 before scaling
    always_comb begin
        ys = signed'({10'h000, pif.pix.y});
        du = signed'({10'h000, pif.pix.cb}) - `RZB_CSC_OFS;
        dv = signed'({10'h000, pif.pix.cr}) - `RZB_CSC_OFS;
        r = rzb_pkg::rzb_clamp(ys + ((`RZB_CSC_RV * dv) >>> `RZB_CSC_SHIFT));
        g = rzb_pkg::rzb_clamp(ys - ((`RZB_CSC_GU * du + `RZB_CSC_GV * dv) >>> `RZB_CSC_SHIFT));
        b = rzb_pkg::rzb_clamp(ys + ((`RZB_CSC_BU * du) >>> `RZB_CSC_SHIFT));
    end

    ////////////////////////////////////////////////////////////////////////
    // packing by output mode
    always_comb begin
        if (!pif.rgb_en) begin
            pif.word = {8'h00, pif.pix.cr, pif.pix.cb, pif.pix.y}; // R8
        end else if (pif.pack16) begin
            pif.word = {16'h0000, r[7:3], g[7:2], b[7:3]}; // R12
        end else begin
            pif.word = {pif.alpha, r, g, b}; // R11 R13
        end
    end
endmodule
`default_nettype wire

// ---- verif/rzb_output_stage_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rzb_regs.svh"
module rzb_output_stage_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb side
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // packed output
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [31:0] out_data
);
    // last written fields
    logic [11:0] s_lpf;
    logic s_en, s_rgb;
    logic [5:0] s_av;
    logic [2:0] s_fmt;
    logic [7:0] s_alpha;
    wire logic acc = psel && penable && pready;
    wire logic rd = acc && !pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // shadows follow completed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {s_lpf, s_en, s_rgb, s_av, s_fmt, s_alpha} <= '0;
        end else if (acc && pwrite) begin
            case (paddr)
                `RZB_OFS_HLPF: s_lpf <= pwdata[11:0];
                `RZB_OFS_DWN_EN: s_en <= pwdata[0];
                `RZB_OFS_DWN_AV: s_av <= pwdata[5:0];
                `RZB_OFS_RGB_EN: s_rgb <= pwdata[0];
                `RZB_OFS_RGB_TYP: s_fmt <= pwdata[2:0];
                `RZB_OFS_ALPHA: s_alpha <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    a_lpf_read: assert property (
        rd && paddr == `RZB_OFS_HLPF |-> prdata == {20'h0, s_lpf}) else $error("lpf read");
    a_en_read: assert property (
        rd && paddr == `RZB_OFS_DWN_EN |-> prdata == {31'h0, s_en}) else $error("en read");
    a_av_read: assert property (
        rd && paddr == `RZB_OFS_DWN_AV |-> prdata == {26'h0, s_av}) else $error("av read");
    a_sel_read: assert property (
        rd && paddr == `RZB_OFS_RGB_EN |-> prdata == {31'h0, s_rgb}) else $error("sel read");
    a_fmt_read: assert property (
        rd && paddr == `RZB_OFS_RGB_TYP |-> prdata == {29'h0, s_fmt}) else $error("fmt read");
    a_alpha_read: assert property (
        rd && paddr == `RZB_OFS_ALPHA |-> prdata == {24'h0, s_alpha}) else $error("alpha read");
    // output word layout
    a_alpha_fill: assert property (
        out_valid && s_rgb && !s_fmt[0] |-> out_data[31:24] == s_alpha) else $error("alpha");
    a_pack_narrow: assert property (
        out_valid && s_rgb && s_fmt[0] |-> out_data[31:16] == 16'h0) else $error("pack16");
    a_ycc_top: assert property (
        out_valid && !s_rgb |-> out_data[31:24] == 8'h00) else $error("ycc top");
    // main scenarios
    c_alpha: cover property (rd && paddr == `RZB_OFS_ALPHA);
    c_narrow: cover property (out_valid && out_ready && s_rgb && s_fmt[0]);
    c_down: cover property (out_valid && out_ready && s_en);
endmodule
bind rzb_output_stage rzb_output_stage_monitor i_rzb_output_stage_monitor (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
);
`default_nettype wire

// ---- verif/rzb_sink_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module rzb_sink_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // stall request from the bench
    input wire logic slow,
    // handshake to the stage
    output logic out_ready
);
    // picks the ready cycle when slow
    logic [2:0] cnt_reg;
    ////////////////////////////////////////////////////////////////
    // writer: always ready, or one cycle in eight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 3'h0;
            out_ready <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
            out_ready <= !slow || cnt_reg == 3'h5;
        end
    end
endmodule
`default_nettype wire

// ---- verif/rzb_output_stage_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rzb_regs.svh"
module rzb_output_stage_tb_top;
    // stimulus
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, out_data, rd, v;
    logic pready, pslverr, in_ready, out_ready, out_valid, out_last, err;
    logic in_valid = 1'b0, in_sof = 1'b0, in_eol = 1'b0, slow = 1'b0;
    logic [7:0] in_y = 8'h00, in_cb = 8'h00, in_cr = 8'h00, g, al;
    logic [23:0] p[4], e, m, prev;
    logic [32:0] exp_q[$];
    logic [31:0] msk[6] = '{32'hfff, 32'h1, 32'h3f, 32'h1, 32'h7, 32'hff};
    logic [31:0] rng = 32'h58afbe5f;
    int fail_count = 0, num_checks = 0;
    always #5 pclk = ~pclk;
    rzb_output_stage #(.LINE_MAX(16)) i_rzb_output_stage (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
        .in_ready(in_ready), .in_sof(in_sof), .in_eol(in_eol), .in_y(in_y), .in_cb(in_cb),
        .in_cr(in_cr), .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last));
    rzb_sink_model i_rzb_sink_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .out_ready(out_ready));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // per-component floor mean
    function automatic logic [23:0] mid(input logic [23:0] a, input logic [23:0] b);
        for (int i = 0; i < 24; i += 8)
            mid[i+:8] = 8'(({1'b0, a[i+:8]} + {1'b0, b[i+:8]}) >> 1);
    endfunction
    function automatic logic [31:0] ycc(input logic [23:0] x);
        return {8'h00, x[7:0], x[15:8], x[23:16]};
    endfunction
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
        num_checks++;
        if (seen !== ex) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, ex, seen);
        end
    endtask
    // apb master
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {err, rd} = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask
    // one sample; released data inverted
    task automatic send(input logic [23:0] x, input logic sof, input logic eol);
        @(posedge pclk);
        {in_valid, in_sof, in_eol, in_y, in_cb, in_cr} <= {1'b1, sof, eol, x};
        do @(posedge pclk); while (in_ready !== 1'b1);
        {in_valid, in_y, in_cb, in_cr} <= {1'b0, ~x};
    endtask
    task automatic drain();
        for (int k = 0; k < 800 && exp_q.size() != 0; k++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk("pending", 33'(exp_q.size()), 33'h0);
        exp_q.delete();
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watcher: accepted word against oldest note
    always @(negedge pclk) begin
        if (presetn && out_valid === 1'b1 && out_ready === 1'b1) begin
            chk("out", {out_last, out_data}, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, random read-back
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk("reset", {err, rd}, 33'h0);
            v = nxt() & msk[i];
            apb(1'b1, 12'(4 * i), v);
            apb(1'b0, 12'(4 * i), 32'h0);
            chk("reg", {err, rd}, {1'b0, v});
            apb(1'b1, 12'(4 * i), 32'h0);
        end
        apb(1'b0, 12'h01c, 32'h0);
        chk("unmapped", {err, rd}, 33'h1_0000_0000);
        // lowpass off, luma full, chroma full
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, `RZB_OFS_HLPF, c == 1 ? 32'h20 : c == 2 ? 32'h800 : 32'h0);
            for (int i = 0; i < 4; i++) begin
                p[0] = 24'(nxt());
                m = mid(p[0], i == 0 ? p[0] : prev);
                e = {c == 1 ? m[23:16] : p[0][23:16], c == 2 ? m[15:0] : p[0][15:0]};
                exp_q.push_back({i == 3, ycc(e)});
                send(p[0], i == 0, i == 3);
                prev = p[0];
            end
            drain();
        end
        // grey pixels, every format, sink stalling
        apb(1'b1, `RZB_OFS_HLPF, 32'h0);
        apb(1'b1, `RZB_OFS_RGB_EN, 32'h1);
        al = 8'(nxt());
        apb(1'b1, `RZB_OFS_ALPHA, {24'h0, al});
        slow <= 1'b1;
        for (int f = 0; f < 8; f++) begin
            apb(1'b1, `RZB_OFS_RGB_TYP, 32'(f));
            for (int i = 0; i < 6; i++) begin
                g = 8'(nxt());
                if (!(f[1] && i < 2) && !(f[2] && i > 3))
                    exp_q.push_back({i == 5, f[0] ? {16'h0, g[7:3], g[7:2], g[7:3]}
                        : {al, g, g, g}});
                send({g, 16'h8080}, i == 0, i == 5);
            end
            drain();
        end
        // block averaging, sizes swapped per pass
        apb(1'b1, `RZB_OFS_RGB_EN, 32'h0);
        apb(1'b1, `RZB_OFS_DWN_EN, 32'h1);
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, `RZB_OFS_DWN_AV, 32'((2 - c) * 8 + c));
            for (int k = 0; k < 4; k++) p[k] = 24'(nxt()) & 24'hfefefe;
            for (int k = 0; k < 2; k++) exp_q.push_back({k == 1, ycc(mid(p[k], p[k + 2]))});
            for (int j = 0; j < (2 << (2 - c)); j++)
                for (int k = 0; k < (4 << c); k++)
                    send(p[(k >> (c + 1)) + (j % 2) * 2], j == 0 && k == 0, k == (4 << c) - 1);
            drain();
        end
        apb(1'b0, `RZB_OFS_STATUS, 32'h0);
        chk("status", {err, rd}, 33'h0_0019_0000);
        stop_test();
    end
endmodule
`default_nettype wire
